// ---- rtl/tisc_map.svh ----
// Offsets, field positions, reset values and masks of the input selector block.
`ifndef TISC_MAP_SVH
`define TISC_MAP_SVH

// Register indices; the APB byte address is four times the index.
`define TISC_IDX_COUNT_READBACK 32'hFFFFF59A
`define TISC_IDX_INPUT_SELECT_0 32'hFFFFF308
`define TISC_IDX_INPUT_SELECT_1 32'hFFFFF30A
`define TISC_IDX_INPUT_SELECT_3 32'hFFFFF30E
`define TISC_IDX_INPUT_SELECT_5 32'hFFFFF3FA
// Index of the control register holding the timer enable bit.
`define TISC_IDX_TIMER_CONTROL  32'hFFFFF5C0

// Number of low index bits that the decoder compares.
`define TISC_IDX_BITS           12

// Reset values.
`define TISC_SEL_RESET          8'h00
`define TISC_COUNT_RESET        16'h0000
`define TISC_CTRL_RESET         1'b0

// Writable bits; the rest are reserved and read as zero.
`define TISC_SEL0_WMASK         8'h7F
`define TISC_SEL1_WMASK         8'h07
`define TISC_SEL3_WMASK         8'h41
`define TISC_SEL5_WMASK         8'hC0

// Field positions.
`define TISC_SEL0_T3IN1_SERIAL  6
`define TISC_SEL0_T3IN0_SERIAL  5
`define TISC_SEL0_T1IN1_SERIAL  4
`define TISC_SEL0_T1IN0_SERIAL  3
`define TISC_SEL0_T0IN1_HI      2
`define TISC_SEL0_T0IN1_LO      1
`define TISC_SEL0_T0IN0_CAN     0
`define TISC_SEL1_T4IN1_SERIAL  2
`define TISC_SEL1_T2IN1_CAN     1
`define TISC_SEL1_T2IN0_CAN     0
`define TISC_SEL3_T5IN0_CAN     6
`define TISC_SEL3_T4IN0_SERIAL  0
`define TISC_SEL5_T6IN1_SERIAL  7
`define TISC_SEL5_T6IN0_SERIAL  6
`define TISC_CTRL_ENABLE_BIT    0

`endif

// ---- rtl/tisc_pkg.sv ----
// Types shared by the timer input selector block.
package tisc_pkg;

    // One bit for each timer capture input that the selectors serve.
    typedef struct packed {
        logic t0In0;
        logic t0In1;
        logic t1In0;
        logic t1In1;
        logic t2In0;
        logic t2In1;
        logic t3In0;
        logic t3In1;
        logic t4In0;
        logic t4In1;
        logic t5In0;
        logic t6In0;
        logic t6In1;
    } tisc_cap_s;

    // Alternative sources that a selector may route to a capture input.
    typedef struct packed {
        logic [7:0] serialReceiveLine;
        logic [4:0] canTimestampOut;
        logic       timerMMatchIrq;
    } tisc_src_s;

    // Source choice of the timer 0 input 1 field.
    typedef enum logic [1:0] {
        T0IN1_PIN = 2'h0,
        T0IN1_CAN = 2'h1,
        T0IN1_TMM = 2'h2
    } tisc_t0in1_e;

endpackage

// ---- rtl/tisc_up_counter.sv ----
// Up-counter of the timer with enable-driven clear.
`timescale 1ns/1ps
`default_nettype none
`include "tisc_map.svh"

module tisc_up_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             enable,
    input  wire logic             countTick,
    output var  logic [WIDTH-1:0] count
);

    initial begin
        if (WIDTH != 16) begin
            $error("tisc_up_counter: WIDTH must be 16");
        end
    end

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // A cleared enable holds the counter at zero, standing in for the stopped operating clock.
    assign count_next = !enable   ? WIDTH'(`TISC_COUNT_RESET) :
                        countTick ? count_reg + WIDTH'(1) : count_reg;

    // Counter state, cleared by system reset.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_reg <= WIDTH'(`TISC_COUNT_RESET);
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule // tisc_up_counter
`default_nettype wire

// ---- rtl/tisc_top.sv ----
// Timer counter readback and capture input selectors behind an APB slave.
//
// Notes on behaviour
// - Counter readback is read-only, whole halfword; writes to it are refused.
// - With timer enable clear, counter readback returns zero.
// - With timer enable set, readback returns the live up-counter value.
// - Any reset clears the counter readback to zero.
// - All selector registers reset to zero, so every input takes its pin.
// - Selectors accept byte writes; single-bit writes arrive as byte writes.
// - Select 0 bits 6..3 route serial lines 3..0 to timer 3/1 inputs.
// - Select 0 bits 2:1 pick pin, CAN 1 timestamp or timer M match.
// - Select 0 bit 0 routes CAN 0 timestamp to timer 0 input 0.
// - Select 1 bits 2..0 route serial 5 and CAN 3/2 timestamps.
// - Select 3 bit 6 routes CAN 4, bit 0 routes serial line 4.
// - Select 5 bits 7 and 6 route serial lines 7 and 6 to timer 6.
// - Clearing timer enable stops and clears the timer counter.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tisc_map.svh"

module tisc_top #(
    parameter int ADDR_W  = 14,
    parameter int COUNT_W = 16
) (
    input  wire logic               sys_clk,
    input  wire logic               reset,
    // APB slave port.
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic                    pready,
    output var  logic [31:0]        prdata,
    output var  logic               pslverr,
    // Count clock tick of the timer.
    input  wire logic               countTick,
    // Dedicated capture pins and alternative sources.
    input  wire tisc_pkg::tisc_cap_s capturePins,
    input  wire tisc_pkg::tisc_src_s altSources,
    // Routed capture inputs toward the timers' edge detectors.
    output tisc_pkg::tisc_cap_s     captureInputs,
    // Timer enable bit, for the rest of the timer.
    output var  logic               timerEnable
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter checks.

    // The decoder needs the index bits plus the two byte-offset bits.
    initial begin
        if (ADDR_W < `TISC_IDX_BITS + 2) begin
            $error("tisc_top: ADDR_W must be at least 14");
        end
        if (COUNT_W != 16) begin
            $error("tisc_top: COUNT_W must be 16");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    // True when the bus word address matches a register index.
    function automatic logic idxHit(input logic [`TISC_IDX_BITS-1:0] word,
                                    input logic [31:0] idx);
        idxHit = (word == idx[`TISC_IDX_BITS-1:0]);
    endfunction

    // Masked selector merge, only when byte lane 0 is strobed.
    function automatic logic [7:0] selMerge(input logic [7:0] cur,
                                            input logic [7:0] wd,
                                            input logic [7:0] mask,
                                            input logic       lane0);
        selMerge = lane0 ? (wd & mask) : cur;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.

    logic [`TISC_IDX_BITS-1:0] wordAddr;
    logic                      aligned;
    logic                      hitCount;
    logic                      hitSel0;
    logic                      hitSel1;
    logic                      hitSel3;
    logic                      hitSel5;
    logic                      hitCtrl;
    logic                      hitAny;
    logic                      setupPhase;
    logic                      accessDone;
    logic                      wrDone;
    logic                      badAccess;

    // The word index sits above the two byte-offset bits; higher address bits are ignored.
    assign wordAddr   = paddr[`TISC_IDX_BITS+1:2];
    assign aligned    = (paddr[1:0] == 2'h0);
    assign hitCount   = aligned && idxHit(wordAddr, `TISC_IDX_COUNT_READBACK);
    assign hitSel0    = aligned && idxHit(wordAddr, `TISC_IDX_INPUT_SELECT_0);
    assign hitSel1    = aligned && idxHit(wordAddr, `TISC_IDX_INPUT_SELECT_1);
    assign hitSel3    = aligned && idxHit(wordAddr, `TISC_IDX_INPUT_SELECT_3);
    assign hitSel5    = aligned && idxHit(wordAddr, `TISC_IDX_INPUT_SELECT_5);
    assign hitCtrl    = aligned && idxHit(wordAddr, `TISC_IDX_TIMER_CONTROL);
    assign hitAny     = hitCount || hitSel0 || hitSel1 || hitSel3 || hitSel5 || hitCtrl;

    // No wait states: every access phase completes at once.
    assign pready     = 1'b1;
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign wrDone     = accessDone && pwrite;

    // No write path into the counter readback; a write answers with an error.
    assign badAccess  = !hitAny || (pwrite && hitCount);

    ////////////////////////////////////////////////////////////////////////////////
    // Selector and control registers.

    logic [7:0] sel0_reg;
    logic [7:0] sel1_reg;
    logic [7:0] sel3_reg;
    logic [7:0] sel5_reg;
    logic       ctrl_reg;
    logic [7:0] sel0_next;
    logic [7:0] sel1_next;
    logic [7:0] sel3_next;
    logic [7:0] sel5_next;
    logic       ctrl_next;

    // Masking keeps reserved bits at zero even if software writes ones there.
    assign sel0_next = (wrDone && hitSel0) ?
                       selMerge(sel0_reg, pwdata[7:0], `TISC_SEL0_WMASK, pstrb[0]) :
                       sel0_reg;
    assign sel1_next = (wrDone && hitSel1) ?
                       selMerge(sel1_reg, pwdata[7:0], `TISC_SEL1_WMASK, pstrb[0]) :
                       sel1_reg;
    assign sel3_next = (wrDone && hitSel3) ?
                       selMerge(sel3_reg, pwdata[7:0], `TISC_SEL3_WMASK, pstrb[0]) :
                       sel3_reg;
    assign sel5_next = (wrDone && hitSel5) ?
                       selMerge(sel5_reg, pwdata[7:0], `TISC_SEL5_WMASK, pstrb[0]) :
                       sel5_reg;
    assign ctrl_next = (wrDone && hitCtrl && pstrb[0]) ?
                       pwdata[`TISC_CTRL_ENABLE_BIT] : ctrl_reg;

    // Out of reset every capture input takes its own pin.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sel0_reg <= `TISC_SEL_RESET;
            sel1_reg <= `TISC_SEL_RESET;
            sel3_reg <= `TISC_SEL_RESET;
            sel5_reg <= `TISC_SEL_RESET;
        end else begin
            sel0_reg <= sel0_next;
            sel1_reg <= sel1_next;
            sel3_reg <= sel3_next;
            sel5_reg <= sel5_next;
        end
    end

    // Timer enable bit, cleared by reset.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= `TISC_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign timerEnable = ctrl_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timer counter.

    logic [COUNT_W-1:0] count;
    logic [15:0]        countReadback;

    // The counter is held cleared while the enable bit is low.
    tisc_up_counter #(
        .WIDTH     (COUNT_W)
    ) u_counter (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .enable    (ctrl_reg),
        .countTick (countTick),
        .count     (count)
    );

    // Reads see zero while disabled, the live count otherwise.
    assign countReadback = ctrl_reg ? count[15:0] :
                                      `TISC_COUNT_RESET;

    ////////////////////////////////////////////////////////////////////////////////
    // Read data path.

    logic [31:0] readMux;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    // Narrow registers read in the low bits, zero above.
    assign readMux = hitCount ? {16'h0000, countReadback} :
                     hitSel0  ? {24'h000000, sel0_reg} :
                     hitSel1  ? {24'h000000, sel1_reg} :
                     hitSel3  ? {24'h000000, sel3_reg} :
                     hitSel5  ? {24'h000000, sel5_reg} :
                     hitCtrl  ? {31'h00000000, ctrl_reg} :
                                32'h00000000;

    // Read data and error are caught in the setup cycle, so they stand through the access
    // phase; the count value is the one at the setup edge.
    assign prdata_next  = setupPhase ? ((!pwrite && !badAccess) ? readMux : 32'h00000000) :
                                       prdata_reg;
    assign pslverr_next = setupPhase ? badAccess : pslverr_reg;

    // Bus answer registers.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Capture input routing.

    tisc_pkg::tisc_t0in1_e t0In1Choice;
    tisc_pkg::tisc_cap_s   routed;

    // A set upper bit selects the timer M match whatever the lower bit says.
    assign t0In1Choice = sel0_reg[`TISC_SEL0_T0IN1_HI] ? tisc_pkg::T0IN1_TMM :
                         sel0_reg[`TISC_SEL0_T0IN1_LO] ? tisc_pkg::T0IN1_CAN :
                                                         tisc_pkg::T0IN1_PIN;

    // Pure combinational selection: no flop sits between source and edge detector, so the
    // timer sees the source exactly as it would see the pin. The price is that switching a
    // selector while the timer runs can fake an edge, which is why software must not.
    always_comb begin
        routed = capturePins;
        unique case (t0In1Choice)
            tisc_pkg::T0IN1_PIN: routed.t0In1 = capturePins.t0In1;
            tisc_pkg::T0IN1_CAN: routed.t0In1 = altSources.canTimestampOut[1];
            tisc_pkg::T0IN1_TMM: routed.t0In1 = altSources.timerMMatchIrq;
            default:             routed.t0In1 = capturePins.t0In1;
        endcase
        if (sel0_reg[`TISC_SEL0_T0IN0_CAN]) begin
            routed.t0In0 = altSources.canTimestampOut[0];
        end
        if (sel0_reg[`TISC_SEL0_T1IN0_SERIAL]) begin
            routed.t1In0 = altSources.serialReceiveLine[0];
        end
        if (sel0_reg[`TISC_SEL0_T1IN1_SERIAL]) begin
            routed.t1In1 = altSources.serialReceiveLine[1];
        end
        if (sel0_reg[`TISC_SEL0_T3IN0_SERIAL]) begin
            routed.t3In0 = altSources.serialReceiveLine[2];
        end
        if (sel0_reg[`TISC_SEL0_T3IN1_SERIAL]) begin
            routed.t3In1 = altSources.serialReceiveLine[3];
        end
        if (sel1_reg[`TISC_SEL1_T2IN0_CAN]) begin
            routed.t2In0 = altSources.canTimestampOut[2];
        end
        if (sel1_reg[`TISC_SEL1_T2IN1_CAN]) begin
            routed.t2In1 = altSources.canTimestampOut[3];
        end
        if (sel1_reg[`TISC_SEL1_T4IN1_SERIAL]) begin
            routed.t4In1 = altSources.serialReceiveLine[5];
        end
        if (sel3_reg[`TISC_SEL3_T4IN0_SERIAL]) begin
            routed.t4In0 = altSources.serialReceiveLine[4];
        end
        if (sel3_reg[`TISC_SEL3_T5IN0_CAN]) begin
            routed.t5In0 = altSources.canTimestampOut[4];
        end
        if (sel5_reg[`TISC_SEL5_T6IN0_SERIAL]) begin
            routed.t6In0 = altSources.serialReceiveLine[6];
        end
        if (sel5_reg[`TISC_SEL5_T6IN1_SERIAL]) begin
            routed.t6In1 = altSources.serialReceiveLine[7];
        end
    end

    assign captureInputs = routed;

endmodule // tisc_top
`default_nettype wire

// ---- test/tisc_src_model.sv ----
// Far-side sources: capture pins, serial lines, CAN stamps and the timer M flag.
`timescale 1ns/1ps
`default_nettype none

module tisc_src_model (
    input  wire logic                sys_clk,
    output var  tisc_pkg::tisc_cap_s capturePins,
    output var  tisc_pkg::tisc_src_s altSources
);
    integer     seed     = 76053;
    logic [1:0] tmmPhase = 2'h0;

    // Start from a known level so the routed outputs are never unknown.
    initial begin
        capturePins = '0;
        altSources = '0;
    end

    // Pins and lines change every cycle; the match flag moves only every fourth cycle.
    always @(posedge sys_clk) begin
        capturePins <= 13'($random(seed));
        altSources.serialReceiveLine <= 8'($random(seed));
        altSources.canTimestampOut <= 5'($random(seed));
        tmmPhase <= tmmPhase + 2'h1;
        if (tmmPhase == 2'h3) begin
            altSources.timerMMatchIrq <= ~altSources.timerMMatchIrq;
        end
    end
endmodule // tisc_src_model
`default_nettype wire

// ---- test/tisc_top_sva.sv ----
// Concurrent checks on the selector block's ports.
`timescale 1ns/1ps
`default_nettype none

module tisc_top_sva #(
    parameter int ADDR_W  = 14,
    parameter int COUNT_W = 16
) (
    input wire logic                sys_clk,
    input wire logic                reset,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [3:0]          pstrb,
    input wire logic                pready,
    input wire logic [31:0]         prdata,
    input wire logic                pslverr,
    input wire logic                countTick,
    input wire tisc_pkg::tisc_cap_s capturePins,
    input wire tisc_pkg::tisc_src_s altSources,
    input wire tisc_pkg::tisc_cap_s captureInputs,
    input wire logic                timerEnable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic [7:0]          sel0_reg, sel1_reg, sel3_reg, sel5_reg;
    logic [15:0]         cnt_reg;
    tisc_pkg::tisc_cap_s expIn;
    wire  [13:0]         addr   = paddr[13:0];
    wire                 wrDone = psel && penable && pready && pwrite && pstrb[0];
    wire                 setup  = psel && !penable;
    wire                 rdCnt  = setup && !pwrite && addr == 14'h1668;
    wire                 selHit = addr inside {14'h0C20, 14'h0C28, 14'h0C38, 14'h0FE8};
    wire  [31:0]         expCnt = timerEnable ? {16'h0000, cnt_reg} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow selectors and counter; reserved bits masked off.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {sel0_reg, sel1_reg, sel3_reg, sel5_reg} <= 32'h0000_0000;
            cnt_reg <= 16'h0000;
        end else begin
            if (wrDone && addr == 14'h0C20) sel0_reg <= pwdata[7:0] & 8'h7F;
            if (wrDone && addr == 14'h0C28) sel1_reg <= pwdata[7:0] & 8'h07;
            if (wrDone && addr == 14'h0C38) sel3_reg <= pwdata[7:0] & 8'h41;
            if (wrDone && addr == 14'h0FE8) sel5_reg <= pwdata[7:0] & 8'hC0;
            cnt_reg <= timerEnable ? cnt_reg + 16'(countTick) : 16'h0000;
        end
    end

    // Expected routing: the pin unless the stored bit picks the alternative.
    always_comb begin
        expIn = capturePins;
        if (sel0_reg[0]) expIn.t0In0 = altSources.canTimestampOut[0];
        if (sel0_reg[2]) expIn.t0In1 = altSources.timerMMatchIrq;
        else if (sel0_reg[1]) expIn.t0In1 = altSources.canTimestampOut[1];
        if (sel0_reg[3]) expIn.t1In0 = altSources.serialReceiveLine[0];
        if (sel0_reg[4]) expIn.t1In1 = altSources.serialReceiveLine[1];
        if (sel0_reg[5]) expIn.t3In0 = altSources.serialReceiveLine[2];
        if (sel0_reg[6]) expIn.t3In1 = altSources.serialReceiveLine[3];
        if (sel1_reg[0]) expIn.t2In0 = altSources.canTimestampOut[2];
        if (sel1_reg[1]) expIn.t2In1 = altSources.canTimestampOut[3];
        if (sel1_reg[2]) expIn.t4In1 = altSources.serialReceiveLine[5];
        if (sel3_reg[0]) expIn.t4In0 = altSources.serialReceiveLine[4];
        if (sel3_reg[6]) expIn.t5In0 = altSources.canTimestampOut[4];
        if (sel5_reg[6]) expIn.t6In0 = altSources.serialReceiveLine[6];
        if (sel5_reg[7]) expIn.t6In1 = altSources.serialReceiveLine[7];
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_route_timer0: assert property (captureInputs[12:11] == expIn[12:11])
        else $error("timer 0 inputs misrouted");
    a_route_serial0: assert property ({captureInputs[10:9], captureInputs[6:5]} == {expIn[10:9], expIn[6:5]})
        else $error("timer 1 or 3 capture inputs misrouted");
    a_route_select1: assert property ({captureInputs[8:7], captureInputs[3]} == {expIn[8:7], expIn[3]})
        else $error("timer 2 or 4 input 1 misrouted");
    a_route_select3: assert property ({captureInputs[4], captureInputs[2]} == {expIn[4], expIn[2]})
        else $error("timer 4 input 0 or timer 5 misrouted");
    a_route_select5: assert property (captureInputs[1:0] == expIn[1:0])
        else $error("timer 6 inputs misrouted");
    a_count_live: assert property (rdCnt |=> prdata == $past(expCnt))
        else $error("readback differs from live count");
    a_count_gated: assert property (rdCnt && !timerEnable |=> prdata == 32'h0)
        else $error("readback not zero while disabled");
    a_count_readonly: assert property (setup && pwrite && addr == 14'h1668 |=> pslverr && prdata == 32'h0)
        else $error("readback write not refused");
    a_reset_clear: assert property ($fell(reset) |-> !timerEnable && prdata == 32'h0 && captureInputs == capturePins)
        else $error("state not cleared after reset");
    a_select_write_ok: assert property (setup && pwrite && selHit |=> !pslverr)
        else $error("selector byte write refused");

    c_count_read: cover property (rdCnt && timerEnable);
    c_match_route: cover property (sel0_reg[2]);
    c_refused: cover property (pslverr);
endmodule // tisc_top_sva
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench of the timer input selector block with a behavioural model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errCount++; $display("mismatch at %0t got %h expected %h", $time, g, e); end end

module testbench;
    localparam logic [13:0] A_CNT     = 14'h1668;
    localparam logic [13:0] A_CTL     = 14'h1700;
    localparam logic [13:0] A_BAD     = 14'h0104;
    localparam logic [13:0] SA [4]    = '{14'h0C20, 14'h0C28, 14'h0C38, 14'h0FE8};
    localparam logic [7:0]  SM [4]    = '{8'h7F, 8'h07, 8'h41, 8'hC0};
    // Routing table entries: selector slot, value, capture bit, source bit.
    localparam logic [31:0] RT [15]   = '{32'h00080A06, 32'h00100907, 32'h00200608,
        32'h00400509, 32'h00010C01, 32'h00020B02, 32'h00040B00, 32'h00060B00, 32'h01010803,
        32'h01020704, 32'h0104030B, 32'h0201040A, 32'h02400205, 32'h0340010C, 32'h0380000D};
    logic                sys_clk, reset, psel, penable, pwrite, countTick, pready, pslverr;
    logic                timerEnable, err, mEn;
    logic [13:0]         paddr;
    logic [31:0]         pwdata, prdata, rd, capCnt;
    logic [3:0]          pstrb;
    logic [7:0]          mSel [4];
    tisc_pkg::tisc_cap_s capturePins, captureInputs, expIn;
    tisc_pkg::tisc_src_s altSources;
    integer              seed = 76053, errCount = 0, comparisons = 0, mCnt = 0;

    tisc_top #(.ADDR_W(14), .COUNT_W(16)) dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .countTick(countTick),
        .capturePins(capturePins), .altSources(altSources), .captureInputs(captureInputs),
        .timerEnable(timerEnable));
    tisc_src_model srcModel (.sys_clk(sys_clk), .capturePins(capturePins), .altSources(altSources));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Counter model and random count ticks, both updated by NBA.
    always @(posedge sys_clk) begin
        countTick <= 1'($random(seed));
        mCnt <= (reset || !mEn) ? 0 : (mCnt + int'(countTick)) % 65536;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One APB transfer; a bounded wait for pready ends a hung run.
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        capCnt = mEn ? 32'(mCnt) : 32'h0;
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errCount++;
            closeOut();
        end
        rd = prdata;
        err = pslverr;
        for (int i = 0; i < 4; i++) if (w && pstrb[0] && a == SA[i]) mSel[i] = d[7:0] & SM[i];
        if (w && pstrb[0] && a == A_CTL) mEn <= d[0];
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdchk(input logic [13:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK({err, rd}, {1'b0, (a == A_CNT) ? capCnt : e})
    endtask

    // Compare routed inputs over four cycles of changing sources.
    task automatic routechk(input int k);
        for (int c = 0; c < 4; c++) begin
            @(negedge sys_clk);
            expIn = capturePins;
            if (k >= 0) expIn[RT[k][15:8]] = altSources[RT[k][7:0]];
            `CHK(captureInputs, expIn)
        end
    endtask

    task automatic regsZero(input string name);
        for (int i = 0; i < 4; i++) rdchk(SA[i], 32'h0);
        rdchk(A_CTL, 32'h0);
        rdchk(A_CNT, 32'h0);
        routechk(-1);
        $display("test %s done, errors %0d", name, errCount);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 46'h0, 4'h1};
        mEn = 1'b0;
        mSel = '{default: 8'h00};
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        regsZero("reset values");
        // Each selector code alone, with the timers disabled.
        for (int k = 0; k < 15; k++) begin
            apb(1'b1, SA[RT[k][25:24]], {24'h0, RT[k][23:16]});
            rdchk(SA[RT[k][25:24]], {24'h0, mSel[RT[k][25:24]]});
            routechk(k);
            apb(1'b1, SA[RT[k][25:24]], 32'h0);
        end
        $display("test routing done, errors %0d", errCount);
        // Refused accesses and a write with the byte strobe off.
        apb(1'b1, A_CNT, 32'h0000_1234);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1'b0, A_BAD, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        pstrb <= 4'h0;
        apb(1'b1, SA[1], 32'h0000_0007);
        pstrb <= 4'h1;
        rdchk(SA[1], 32'h0);
        $display("test refusals done, errors %0d", errCount);
        // Live count at varied spacing, then disable and restart.
        apb(1'b1, A_CTL, 32'h1);
        `CHK(timerEnable, 1'b1)
        for (int i = 0; i < 10; i++) begin
            repeat (i) @(posedge sys_clk);
            rdchk(A_CNT, 32'h0);
        end
        apb(1'b1, A_CTL, 32'h0);
        rdchk(A_CNT, 32'h0);
        apb(1'b1, SA[0], $random(seed) & 32'h7F);
        apb(1'b1, A_CTL, 32'h1);
        repeat (20) @(posedge sys_clk);
        rdchk(A_CNT, 32'h0);
        $display("test counter done, errors %0d", errCount);
        // Mid-run reset with select 0 set and the timer counting.
        repeat (15) @(posedge sys_clk);
        reset <= 1'b1;
        mEn <= 1'b0;
        mSel = '{default: 8'h00};
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        regsZero("mid-run reset");
        closeOut();
    end
endmodule // testbench

bind tisc_top tisc_top_sva #(.ADDR_W(ADDR_W), .COUNT_W(COUNT_W)) sva0 (.sys_clk(sys_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .countTick(countTick), .capturePins(capturePins), .altSources(altSources),
    .captureInputs(captureInputs), .timerEnable(timerEnable));
`default_nettype wire
